// >>> rtl/cprc_top.sv
// Clock divider, idle/power-down control, reset qualifier and watchdog
`timescale 1ns/100ps
`default_nettype none
`include "cprc_cfg.svh"
module cprc_top #(
    parameter int WDOG_BASE_CYCLES = `CPRC_WDOG_BASE
) (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins and requests
    input wire logic rst_pin_i,
    input wire logic irq_req_i,
    // Clock, reset, register and interrupt outputs
    output var cprc_pkg::cprc_clk_type clk_en_o,
    output logic sys_rst_o,
    output var logic [7:0] port_latch_o,
    output var logic [7:0] stack_ptr_o,
    output logic irq_o
);
// ****************************************************************
// State
// ****************************************************************
cprc_pkg::cprc_mode_type mode_q, mode_d;
cprc_pkg::cprc_clk_type clk_q, clk_d;
logic div_q, div_d;
logic [3:0] ph_q, ph_d;
logic pin_prev_q;
logic [1:0] hi_cnt_q, hi_cnt_d;
logic [4:0] pwr_q, pwr_d;
logic [6:0] wdt_q, wdt_d;
logic [2:0] stat_q, stat_d;
logic [2:0] mask_q, mask_d;
logic [7:0] port_q, port_d;
logic [7:0] sp_q, sp_d;
logic [7:0] serial_data_buffer_q, serial_data_buffer_d;
logic [31:0] wcnt_q, wcnt_d;
logic [31:0] prdata_d;
logic osc_run;
logic sample_pt;
logic pin_ok;
logic qual;
logic wd_run;
logic wd_to;
logic wd_rst;
logic [31:0] wlim;
logic wr;
logic hit;
logic [2:0] ev;

// ****************************************************************
// Bus decode
// ****************************************************************
always_comb
begin
    case (paddr)
        `CPRC_OFS_PWR, `CPRC_OFS_WDT, `CPRC_OFS_STAT, `CPRC_OFS_MASK,
        `CPRC_OFS_STATE, `CPRC_OFS_PORT, `CPRC_OFS_SP, `CPRC_OFS_SERIAL_DATA_BUFFER:
            hit = 1'b1;
        default:
            hit = 1'b0;
    endcase
end

assign pready = 1'b1;
assign pslverr = psel & penable & ~hit;
assign wr = psel & penable & pwrite & hit;

// Read data captured in the setup phase
always_comb
begin
    prdata_d = prdata;
    if (psel && !penable)
    begin
        case (paddr)
            `CPRC_OFS_PWR: prdata_d = {27'h0, pwr_q};
            `CPRC_OFS_WDT: prdata_d = {25'h0, wdt_q};
            `CPRC_OFS_STAT: prdata_d = {29'h0, stat_q};
            `CPRC_OFS_MASK: prdata_d = {29'h0, mask_q};
            `CPRC_OFS_STATE:
                prdata_d = {22'h0, hi_cnt_q, ph_q, 1'b0, mode_q};
            `CPRC_OFS_PORT: prdata_d = {24'h0, port_q};
            `CPRC_OFS_SP: prdata_d = {24'h0, sp_q};
            `CPRC_OFS_SERIAL_DATA_BUFFER: prdata_d = {24'h0, serial_data_buffer_q};
            default: prdata_d = 32'h0;
        endcase
    end
end

always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        prdata <= 32'h0;
    else
        prdata <= prdata_d;
end

// ****************************************************************
// Timing: divider, phases, reset sampling, watchdog
// ****************************************************************
assign osc_run = (mode_q != cprc_pkg::cprc_pdown);
assign sample_pt = osc_run && (ph_q == `CPRC_SAMPLE_PH);
assign pin_ok = rst_pin_i & pin_prev_q;
assign qual = sample_pt && pin_ok
    && (hi_cnt_q == `CPRC_RST_SAMPLES - 2'h1);
assign wlim = 32'(WDOG_BASE_CYCLES)
    << wdt_q[`CPRC_WDT_SEL +: 3];
assign wd_run = osc_run && wdt_q[`CPRC_WDT_EN]
    && ((mode_q == cprc_pkg::cprc_run)
    || (mode_q == cprc_pkg::cprc_idle && wdt_q[`CPRC_WDT_IDLE]));
assign wd_to = wd_run && !wdt_q[`CPRC_WDT_CLR]
    && (wcnt_q == wlim - 32'h1);
assign wd_rst = wd_to && wdt_q[`CPRC_WDT_RSTEN];

always_comb
begin
    // Toggle halves the oscillator; frozen when it stops
    div_d = osc_run ? ~div_q : div_q;
    ph_d = ph_q;
    if (osc_run)
        ph_d = (ph_q == `CPRC_PH_LAST) ? 4'h0 : ph_q + 4'h1;
    hi_cnt_d = hi_cnt_q;
    if (sample_pt)
    begin
        if (!pin_ok)
            hi_cnt_d = 2'h0;
        else if (hi_cnt_q != `CPRC_RST_SAMPLES)
            hi_cnt_d = hi_cnt_q + 2'h1;
    end
    wcnt_d = wcnt_q;
    if (wdt_q[`CPRC_WDT_CLR] || wd_to || !wdt_q[`CPRC_WDT_EN])
        wcnt_d = 32'h0;
    else if (wd_run)
        wcnt_d = wcnt_q + 32'h1;
end

always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        div_q <= 1'b0;
        ph_q <= 4'h0;
        pin_prev_q <= 1'b0;
        hi_cnt_q <= 2'h0;
        wcnt_q <= 32'h0;
    end
    else
    begin
        div_q <= div_d;
        ph_q <= ph_d;
        pin_prev_q <= rst_pin_i;
        hi_cnt_q <= hi_cnt_d;
        wcnt_q <= wcnt_d;
    end
end

// ****************************************************************
// Mode control and registers
// ****************************************************************
always_comb
begin
    mode_d = mode_q;
    pwr_d = pwr_q;
    wdt_d = wdt_q;
    mask_d = mask_q;
    port_d = port_q;
    sp_d = sp_q;
    serial_data_buffer_d = serial_data_buffer_q;
    ev = 3'h0;
    wdt_d[`CPRC_WDT_CLR] = 1'b0;
    if (wr)
    begin
        case (paddr)
            `CPRC_OFS_PWR: pwr_d = pwdata[4:0];
            `CPRC_OFS_WDT: wdt_d = pwdata[6:0];
            `CPRC_OFS_MASK: mask_d = pwdata[2:0];
            `CPRC_OFS_PORT: port_d = pwdata[7:0];
            `CPRC_OFS_SP: sp_d = pwdata[7:0];
            `CPRC_OFS_SERIAL_DATA_BUFFER: serial_data_buffer_d = pwdata[7:0];
            default: ;
        endcase
    end
    case (mode_q)
        cprc_pkg::cprc_run:
        begin
            if (qual || wd_rst)
                mode_d = cprc_pkg::cprc_reset;
            else if (pwr_q[`CPRC_PWR_PD])
                mode_d = cprc_pkg::cprc_pdown;
            else if (pwr_q[`CPRC_PWR_IDLE])
                mode_d = cprc_pkg::cprc_idle;
        end
        cprc_pkg::cprc_idle:
        begin
            if (qual || wd_rst)
                mode_d = cprc_pkg::cprc_reset;
            else if (pwr_q[`CPRC_PWR_PD])
                mode_d = cprc_pkg::cprc_pdown;
            else if (irq_req_i)
            begin
                mode_d = cprc_pkg::cprc_run;
                pwr_d[`CPRC_PWR_IDLE] = 1'b0;
                ev[`CPRC_IRQ_WAKE] = 1'b1;
            end
        end
        cprc_pkg::cprc_pdown:
        begin
            // Only the reset pin restarts the oscillator
            if (rst_pin_i)
                mode_d = cprc_pkg::cprc_wake;
        end
        cprc_pkg::cprc_wake:
        begin
            if (qual)
                mode_d = cprc_pkg::cprc_reset;
            else if (sample_pt && !pin_ok)
                mode_d = cprc_pkg::cprc_pdown;
        end
        cprc_pkg::cprc_reset:
        begin
            if (sample_pt && !pin_ok)
                mode_d = cprc_pkg::cprc_run;
        end
        default:
            mode_d = cprc_pkg::cprc_reset;
    endcase
    if (wd_to)
        ev[`CPRC_IRQ_WDOG] = 1'b1;
    if (mode_d == cprc_pkg::cprc_reset && mode_q != cprc_pkg::cprc_reset)
        ev[`CPRC_IRQ_RESET] = 1'b1;
    if (mode_q == cprc_pkg::cprc_reset)
    begin
        pwr_d = pwr_q & `CPRC_PWR_POR;
        wdt_d = 7'h0;
        port_d = `CPRC_PORT_RST;
        sp_d = `CPRC_SP_RST;
        serial_data_buffer_d = serial_data_buffer_q;
    end
    // Status: write one clears, a new event wins
    stat_d = stat_q;
    if (wr && paddr == `CPRC_OFS_STAT)
        stat_d = stat_q & ~pwdata[2:0];
    stat_d = stat_d | ev;
    clk_d.osc_en = (mode_d != cprc_pkg::cprc_pdown);
    clk_d.periph_en = clk_d.osc_en & div_d;
    clk_d.cpu_en = (mode_d == cprc_pkg::cprc_run) & div_d;
end

always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        mode_q <= cprc_pkg::cprc_reset;
        clk_q <= '0;
        pwr_q <= `CPRC_PWR_POR;
        wdt_q <= 7'h0;
        stat_q <= 3'h0;
        mask_q <= 3'h0;
        port_q <= `CPRC_PORT_RST;
        sp_q <= `CPRC_SP_RST;
        serial_data_buffer_q <= 8'h0;
    end
    else
    begin
        mode_q <= mode_d;
        clk_q <= clk_d;
        pwr_q <= pwr_d;
        wdt_q <= wdt_d;
        stat_q <= stat_d;
        mask_q <= mask_d;
        port_q <= port_d;
        sp_q <= sp_d;
        serial_data_buffer_q <= serial_data_buffer_d;
    end
end

assign clk_en_o = clk_q;
assign sys_rst_o = (mode_q == cprc_pkg::cprc_reset);
assign port_latch_o = port_q;
assign stack_ptr_o = sp_q;
assign irq_o = |(stat_q & mask_q);

// ****************************************************************
// Assertions
// ****************************************************************
sequence s_idle_held;
    (mode_q == cprc_pkg::cprc_idle) [*2];
endsequence

sequence s_osc_held;
    osc_run [*2];
endsequence

AST_CLK_DIV: assert property (@(posedge pclk) disable iff (!presetn)
    s_osc_held |-> div_q != $past(div_q))
    else $error("divider did not toggle");

AST_IDLE_CPU_OFF: assert property (@(posedge pclk)
    disable iff (!presetn)
    mode_q == cprc_pkg::cprc_idle |-> !clk_q.cpu_en)
    else $error("cpu clock running in idle");

AST_IDLE_PERIPH: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_idle_held |-> clk_q.periph_en != $past(clk_q.periph_en))
    else $error("peripheral clock stopped in idle");

AST_IDLE_WAKE: assert property (@(posedge pclk)
    disable iff (!presetn)
    mode_q == cprc_pkg::cprc_idle && irq_req_i
    |=> mode_q != cprc_pkg::cprc_idle ##1 clk_q.cpu_en || !div_q)
    else $error("idle not left on interrupt");

AST_PD_OSC: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == cprc_pkg::cprc_pdown |-> !clk_q.osc_en && !clk_q.cpu_en)
    else $error("clock running in power-down");

AST_PD_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == cprc_pkg::cprc_pdown && !rst_pin_i
    |=> mode_q == cprc_pkg::cprc_pdown)
    else $error("power-down left without reset");

AST_SAMPLE: assert property (@(posedge pclk) disable iff (!presetn)
    hi_cnt_q != $past(hi_cnt_q) |-> $past(ph_q) == `CPRC_SAMPLE_PH)
    else $error("reset pin sampled off the sample point");

AST_RST_QUAL: assert property (@(posedge pclk)
    disable iff (!presetn)
    $rose(sys_rst_o) && !$past(wd_rst)
    |-> $past(hi_cnt_q) == 2'h1 && $past(sample_pt) && $past(pin_ok))
    else $error("reset taken without two held samples");

AST_RST_VALUES: assert property (@(posedge pclk)
    disable iff (!presetn)
    $past(sys_rst_o) |-> port_q == `CPRC_PORT_RST
    && sp_q == `CPRC_SP_RST && pwr_q[3:0] == 4'h0 && wdt_q == 7'h0)
    else $error("reset values not loaded");

AST_SERIAL_DATA_BUFFER_KEEP: assert property (@(posedge pclk)
    disable iff (!presetn)
    $past(sys_rst_o) |-> serial_data_buffer_q == $past(serial_data_buffer_q))
    else $error("serial buffer disturbed by reset");

AST_WDOG_PERIOD: assert property (@(posedge pclk)
    disable iff (!presetn)
    wd_to |=> stat_q[`CPRC_IRQ_WDOG] && wcnt_q == 32'h0)
    else $error("watchdog time-out not flagged");

AST_PD_PRIO: assert property (@(posedge pclk)
    disable iff (!presetn)
    mode_q == cprc_pkg::cprc_run && pwr_q[1:0] == 2'h3
    && !qual && !wd_rst |=> mode_q == cprc_pkg::cprc_pdown)
    else $error("power-down not preferred over idle");
endmodule
`default_nettype wire

// >>> rtl/cprc_cfg.svh
// Constants of the clock, power and reset control block
// Function
// - Divide the oscillator clock by two before internal use.
// - Setting the idle request bit stops the processor clock.
// - In idle, peripherals and interrupt logic stay clocked.
// - Interrupt or reset ends idle and restores the processor clock.
// - Setting the power-down request bit stops all clocks and the oscillator.
// - In power-down, interrupts are ignored; only reset resumes operation.
// - Sample the reset pin once per machine cycle at state 5 phase 2.
// - Filter reset glitches; only a properly held high level resets.
// - During reset, port latches load all ones and stack pointer seven.
// - During reset, power control clears to zero except bit 4.
// - During reset, other control registers clear; serial buffer keeps value; the code also keeps the interrupt mask.
// - Watchdog time-out 19.66 ms at code 000, doubling per code step.
// - Power-off flag in bit 4 set on power-on; software may clear.
// - Power control bit 0 requests idle, bit 1 requests power-down.
`ifndef CPRC_CFG_SVH
`define CPRC_CFG_SVH
// ****************************************************************
// Timing
// ****************************************************************
`define CPRC_CLK_NS 50
`define CPRC_PH_LAST 4'hB
`define CPRC_SAMPLE_PH 4'h9
`define CPRC_RST_SAMPLES 2'h2
`define CPRC_WDOG_T0_NS 19660000
`define CPRC_WDOG_BASE (`CPRC_WDOG_T0_NS / `CPRC_CLK_NS)
// ****************************************************************
// Register offsets
// ****************************************************************
`define CPRC_OFS_PWR 8'h00
`define CPRC_OFS_WDT 8'h04
`define CPRC_OFS_STAT 8'h08
`define CPRC_OFS_MASK 8'h0C
`define CPRC_OFS_STATE 8'h10
`define CPRC_OFS_PORT 8'h14
`define CPRC_OFS_SP 8'h18
`define CPRC_OFS_SERIAL_DATA_BUFFER 8'h1C
// ****************************************************************
// Fields and reset values
// ****************************************************************
`define CPRC_PWR_IDLE 0
`define CPRC_PWR_PD 1
`define CPRC_PWR_POF 4
`define CPRC_WDT_EN 0
`define CPRC_WDT_CLR 1
`define CPRC_WDT_IDLE 2
`define CPRC_WDT_RSTEN 3
`define CPRC_WDT_SEL 4
`define CPRC_IRQ_WDOG 0
`define CPRC_IRQ_RESET 1
`define CPRC_IRQ_WAKE 2
`define CPRC_PWR_POR 5'h10
`define CPRC_PORT_RST 8'hFF
`define CPRC_SP_RST 8'h07
`endif

// >>> rtl/cprc_pkg.sv
// Types of the clock, power and reset control block
package cprc_pkg;
    typedef enum logic [2:0]
    {
        cprc_run,
        cprc_idle,
        cprc_pdown,
        cprc_wake,
        cprc_reset
    } cprc_mode_type;

    typedef struct packed
    {
        logic osc_en;
        logic periph_en;
        logic cpu_en;
    } cprc_clk_type;
endpackage

// >>> bench/cprc_rst_src.sv
// Model of the external reset source driving the reset pin
`timescale 1ns/100ps
`default_nettype none
module cprc_rst_src (
    // Oscillator clock
    input wire logic pclk,
    // Reset pin, falls to its pull-down level when released
    output var logic rst_pin_o
);
    initial rst_pin_o = 1'b0;
    // Hold the pin high for n clocks, then release it
    task automatic press(input int n);
        @(posedge pclk);
        rst_pin_o <= 1'b1;
        repeat (n) @(posedge pclk);
        rst_pin_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> bench/test_clock_power_reset_control.sv
// Self-checking bench of the clock, power and reset control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) \
    begin checked++; if ((a) !== (e)) begin miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
`define WAIT(c, m) \
    begin for (n = 0; n < m && !(c); n++) @(negedge pclk); \
    if (!(c)) begin miscompares++; wrap_up; end end
module test_clock_power_reset_control;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rst_pin;
    logic irq_req = 1'b0;
    cprc_pkg::cprc_clk_type clk_en;
    logic sys_rst;
    logic [7:0] port_latch;
    logic [7:0] stack_ptr;
    logic irq;
    logic [31:0] rdat;
    logic rerr;
    int miscompares = 0;
    int checked = 0;
    int n;
    always #25 pclk = ~pclk;
    cprc_top #(.WDOG_BASE_CYCLES(16)) u_cprc_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rst_pin_i(rst_pin),
        .irq_req_i(irq_req), .clk_en_o(clk_en), .sys_rst_o(sys_rst),
        .port_latch_o(port_latch), .stack_ptr_o(stack_ptr), .irq_o(irq));
    cprc_rst_src u_cprc_rst_src (.pclk(pclk), .rst_pin_o(rst_pin));
    // ****************************************************************
    // Bus and report tasks
    // ****************************************************************
    task automatic wrap_up;
        if (miscompares == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 20)
        begin
            miscompares++;
            wrap_up;
        end
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        `CHK(port_latch, 8'hFF)
        `CHK(stack_ptr, 8'h07)
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rdat, 32'h10)
        apb(1'b0, 8'h20, 32'h0);
        `CHK({rerr, rdat}, 33'h100000000)
    endtask
    task automatic t_div;
        logic p;
        @(negedge pclk);
        p = clk_en.cpu_en;
        repeat (6)
        begin
            @(negedge pclk);
            `CHK({clk_en.osc_en, clk_en.cpu_en}, {1'b1, ~p})
            p = clk_en.cpu_en;
        end
    endtask
    task automatic t_idle;
        int hi;
        hi = 0;
        apb(1'b1, 8'h0C, 32'h0);
        apb(1'b1, 8'h00, 32'h1);
        repeat (4) @(negedge pclk);
        repeat (10)
        begin
            @(negedge pclk);
            `CHK(clk_en.cpu_en, 1'b0)
            hi += clk_en.periph_en;
        end
        `CHK(hi, 5)
        @(posedge pclk);
        irq_req <= 1'b1;
        `WAIT(clk_en.cpu_en === 1'b1, 8)
        @(posedge pclk);
        irq_req <= 1'b0;
        apb(1'b0, 8'h08, 32'h0);
        `CHK({irq, rdat[2]}, 2'b01)
        apb(1'b1, 8'h0C, 32'h4);
        @(negedge pclk);
        `CHK(irq, 1'b1)
        apb(1'b1, 8'h08, 32'h4);
        @(negedge pclk);
        `CHK(irq, 1'b0)
    endtask
    task automatic t_wdog;
        int c;
        apb(1'b1, 8'h0C, 32'h1);
        for (c = 0; c < 3; c++)
        begin
            apb(1'b1, 8'h04, {25'h0, c[2:0], 4'h3});
            repeat ((16 << c) - 6) @(negedge pclk);
            `CHK(irq, 1'b0)
            `WAIT(irq === 1'b1, 20)
            apb(1'b1, 8'h04, 32'h0);
            apb(1'b1, 8'h08, 32'h1);
        end
        // Time-out with reset enabled enters reset and clears the watchdog
        apb(1'b1, 8'h04, 32'h9);
        `WAIT(sys_rst === 1'b1, 40)
        `WAIT(sys_rst === 1'b0, 40)
        `CHK({port_latch, stack_ptr}, 16'hFF07)
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rdat, 32'h0)
        apb(1'b1, 8'h08, 32'h7);
    endtask
    task automatic t_glitch;
        int i;
        for (i = 0; i < 2; i++)
        begin
            u_cprc_rst_src.press(i * 11 + 1);
            repeat (30)
            begin
                @(negedge pclk);
                `CHK(sys_rst, 1'b0)
            end
        end
    endtask
    task automatic t_pd;
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h14, 32'h5A);
        apb(1'b1, 8'h18, 32'h33);
        apb(1'b1, 8'h1C, 32'hA5);
        `CHK({port_latch, stack_ptr}, 16'h5A33)
        apb(1'b1, 8'h00, 32'h3);
        repeat (3) @(posedge pclk);
        irq_req <= 1'b1;
        repeat (20)
        begin
            @(negedge pclk);
            `CHK(clk_en, 3'b000)
        end
        @(posedge pclk);
        irq_req <= 1'b0;
        `CHK(clk_en, 3'b000)
        // A short pin pulse only wakes the oscillator, then it stops again
        u_cprc_rst_src.press(2);
        repeat (30)
        begin
            @(negedge pclk);
            `CHK(sys_rst, 1'b0)
        end
        `CHK(clk_en, 3'b000)
        fork
            u_cprc_rst_src.press(40);
            `WAIT(sys_rst === 1'b1, 60)
        join
        `WAIT(sys_rst === 1'b0, 40)
        `CHK({port_latch, stack_ptr}, 16'hFF07)
        `CHK(clk_en.osc_en, 1'b1)
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rdat, 32'h0)
        apb(1'b0, 8'h1C, 32'h0);
        `CHK(rdat, 32'hA5)
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rdat, 32'h0)
        apb(1'b0, 8'h10, 32'h0);
        `CHK(rdat[2:0], 3'h0)
    endtask
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        `WAIT(sys_rst === 1'b0, 40)
        t_reset;
        t_div;
        t_idle;
        t_wdog;
        t_glitch;
        t_pd;
        wrap_up;
    end
endmodule
`default_nettype wire
